//--- include/serial_irq_pkg.sv
`default_nettype none

package serial_irq_pkg;

	// ----------------------------------------
	// Frame geometry
	// ----------------------------------------
	localparam int FRAME_CLKS = 3;
	localparam int FRAMES_MIN = 17;
	localparam int SLOT_LAST_FRAME = 16;
	localparam int SLOT_SMI_IRQ2 = 2;
	localparam int SLOT_IRQ13 = 13;
	localparam logic [1:0] PH_RECOVER = 2'h0;
	localparam logic [1:0] PH_TURN = 2'h1;
	localparam logic [1:0] PH_SAMPLE = 2'h2;
	localparam logic [7:0] CNT_MAX = 8'hff;

	// ----------------------------------------
	// Start and stop widths, in link clocks
	// ----------------------------------------
	localparam logic [2:0] HOST_START_MIN = 3'h3;
	localparam logic [2:0] HOST_START_MAX = 3'h7;
	localparam logic [7:0] STOP_QUIET_CLKS = 8'h02;
	localparam logic [7:0] STOP_CONT_CLKS = 8'h03;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int SYS_PERIOD_NS = 4;
	localparam int LINK_PERIOD_NS = 48;
	localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);

	// ----------------------------------------
	// Slot arithmetic
	// ----------------------------------------
	function automatic logic [1:0] phase_of(input logic [7:0] clk_no);
		logic [7:0] r;
		r = clk_no % 8'h03;
		return r[1:0];
	endfunction : phase_of

	function automatic logic [7:0] frame_of(input logic [7:0] clk_no);
		logic [8:0] s;
		s = {1'b0, clk_no} + 9'h001;
		return 8'(s / 9'h003);
	endfunction : frame_of

endpackage : serial_irq_pkg

`default_nettype wire

//--- include/serial_irq_if.sv
`default_nettype none

interface serial_irq_if;
	logic pci_clk;
	logic bus_rst;
	logic host_o;
	logic host_oe;
	logic dev_o;
	logic dev_oe;
	logic line;

	// ----------------------------------------
	// Shared wire with pull-up: any driven low wins
	// ----------------------------------------
	assign line = !((host_oe && !host_o) || (dev_oe && !dev_o));

	modport host (output pci_clk, output bus_rst, output host_o, output host_oe, input line);
	modport device (input pci_clk, input bus_rst, output dev_o, output dev_oe, input line);
endinterface : serial_irq_if

`default_nettype wire

//--- core/serial_irq_host_ctrl.sv
`default_nettype none

module serial_irq_host_ctrl
	import serial_irq_pkg::*;
#(
	parameter int NUM_FRAMES = FRAMES_MIN,
	parameter int HALF_CYC = LINK_HALF_CYC
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	serial_irq_if.host link,
	input wire logic [2:0] start_low,
	input wire logic stop_quiet,
	input wire logic run_continuous,
	input wire logic cycle_req,
	input wire logic bus_rst_req,
	output logic [15:0] slot_lvl,
	output logic cycle_done,
	output logic quiet_mode
);

	typedef enum logic [4:0] {
		H_IDLE = 5'b00001,
		H_START = 5'b00010,
		H_HIGH = 5'b00100,
		H_FRAMES = 5'b01000,
		H_STOP = 5'b10000
	} host_state_e;

	localparam logic [7:0] LAST_CLK = 8'(FRAME_CLKS * NUM_FRAMES + 1);

	host_state_e state_r;
	logic [7:0] cnt_r;
	logic [7:0] div_r;
	logic pci_r;
	logic rst_r;
	logic line_s1;
	logic line_s2;
	logic quiet_r;
	logic stop_q_r;
	logic oe_r;
	logic o_r;
	logic [15:0] lvl_r;
	logic done_r;
	logic tick;
	logic [2:0] low_len;
	logic [7:0] frame;

	// ----------------------------------------
	// Link clock divider and bus reset
	// ----------------------------------------
	assign tick = ce && (div_r == 8'(HALF_CYC - 1)) && !pci_r;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			div_r <= 8'h00;
			pci_r <= 1'b0;
			rst_r <= 1'b1;
		end else if (ce) begin
			rst_r <= bus_rst_req;
			if (div_r == 8'(HALF_CYC - 1)) begin
				div_r <= 8'h00;
				pci_r <= !pci_r;
			end else begin
				div_r <= div_r + 8'h01;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			line_s1 <= 1'b1;
			line_s2 <= 1'b1;
		end else if (ce) begin
			line_s1 <= link.line;
			line_s2 <= line_s1;
		end
	end

	// Host's share of the start pulse, clamped to the legal range
	assign low_len = (start_low < HOST_START_MIN) ? HOST_START_MIN :
		(start_low > HOST_START_MAX) ? HOST_START_MAX : start_low; // RL1 RL5
	assign frame = frame_of(cnt_r);

	// ----------------------------------------
	// Cycle sequencer, one step per link clock
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_r <= H_IDLE;
			cnt_r <= 8'h00;
			quiet_r <= 1'b0;
			stop_q_r <= 1'b0;
			oe_r <= 1'b0;
			o_r <= 1'b1;
			lvl_r <= 16'hffff;
			done_r <= 1'b0;
		end else if (ce) begin
			done_r <= 1'b0;
			if (rst_r) begin
				state_r <= H_IDLE; // RL23
				quiet_r <= 1'b0;
				oe_r <= 1'b0;
				o_r <= 1'b1;
			end else if (tick) begin
				unique case (state_r)
					H_IDLE: begin
						if (quiet_r && !line_s2) begin
							state_r <= H_START; // RL5
							cnt_r <= 8'h01;
							oe_r <= 1'b1;
							o_r <= 1'b0;
						end else if (cycle_req || (!quiet_r && run_continuous)) begin
							state_r <= H_START; // RL8 RL21
							cnt_r <= 8'h00;
							oe_r <= 1'b1;
							o_r <= 1'b0;
						end
					end
					H_START: begin
						if (cnt_r == 8'(low_len)) begin
							state_r <= H_HIGH;
							o_r <= 1'b1; // RL5
						end else begin
							cnt_r <= cnt_r + 8'h01;
						end
					end
					H_HIGH: begin
						state_r <= H_FRAMES;
						cnt_r <= 8'h01;
						oe_r <= 1'b0;
					end
					H_FRAMES: begin
						cnt_r <= cnt_r + 8'h01;
						if (phase_of(cnt_r) == PH_SAMPLE && frame >= 8'h02 && frame <= 8'(SLOT_LAST_FRAME))
							lvl_r[4'(frame - 8'h01)] <= line_s2; // RL22
						if (cnt_r == LAST_CLK) begin
							state_r <= H_STOP; // RL20
							cnt_r <= 8'h01;
							stop_q_r <= stop_quiet;
							oe_r <= 1'b1;
							o_r <= 1'b0;
						end
					end
					H_STOP: begin
						if (o_r) begin
							state_r <= H_IDLE;
							oe_r <= 1'b0;
							done_r <= 1'b1;
						end else if (cnt_r == (stop_q_r ? STOP_QUIET_CLKS : STOP_CONT_CLKS)) begin
							o_r <= 1'b1; // RL2
							quiet_r <= stop_q_r; // RL9
						end else begin
							cnt_r <= cnt_r + 8'h01;
						end
					end
				endcase
			end
		end
	end

	assign link.pci_clk = pci_r;
	assign link.bus_rst = rst_r;
	assign link.host_oe = oe_r;
	assign link.host_o = o_r;
	assign slot_lvl = lvl_r;
	assign cycle_done = done_r;
	assign quiet_mode = quiet_r;

endmodule : serial_irq_host_ctrl

`default_nettype wire

//--- core/serial_irq_slave_agent.sv
// Operation
// RL1: Host start pulse low four to eight clocks
// RL2: Stop two clocks quiet, three continuous
// RL3: Device start: one low clock, never high
// RL4: No device start while cycle active
// RL5: Host extends start low, then drives high
// RL6: Quiet mode: line change triggers start frame
// RL7: Continuous mode: device never starts frames
// RL8: Host may run continuous cycles back-to-back
// RL9: Mode changes only during stop frame
// RL10: Reset leaves device in continuous mode
// RL11: Stop width sets next cycle mode
// RL12: Frames of three clocks from start rise
// RL13: Sample phase drives low for low level
// RL14: Recovery drives high after own low; turn releases
// RL15: Report slots whoever started the frame
// RL16: Frame n samples 3n-1 clocks after rise
// RL17: Frame three carries management interrupt or irq2
// RL18: Frame fourteen carries interrupt thirteen
// RL19: Enable bits gate management frame and pin
// RL20: Only host issues stop after data frames
// RL21: Next start from second clock after stop
// RL22: Drive and sample on link clock rise
// RL23: Bus reset releases line, enters continuous idle
// RL24: Register levels, compare with last reported

`default_nettype none

module serial_irq_slave_agent
	import serial_irq_pkg::*;
#(
	parameter int NUM_FRAMES = FRAMES_MIN
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	serial_irq_if.device link,
	input wire logic [15:0] irq_lvl,
	input wire logic smi_req,
	input wire logic smi_serial_en,
	input wire logic smi_pin_en,
	input wire logic irq2_on_slot3,
	output logic sys_mgmt_irq_out_n,
	output logic quiet_mode,
	output logic cycle_active
);

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_START = 4'b0010,
		ST_FRAMES = 4'b0100,
		ST_STOP = 4'b1000
	} agent_state_e;

	// Stop can only start once the last data frame is over
	localparam logic [7:0] STOP_FROM = 8'(FRAME_CLKS * NUM_FRAMES + 2);

	agent_state_e state_r;
	agent_state_e state_nxt;
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	logic quiet_r;
	logic quiet_nxt;
	logic pci_s1;
	logic pci_s2;
	logic pci_q;
	logic line_s1;
	logic line_s2;
	logic line_q;
	logic brst_s1;
	logic brst_s2;
	logic tick;
	logic [15:0] slot_raw;
	logic [15:0] lvl_r;
	logic [15:0] reported_r;
	logic pending;
	logic drove_r;
	logic oe_r;
	logic o_r;
	logic smi_n_r;
	logic [7:0] frame;
	logic [1:0] phase;
	logic [3:0] slot_idx;
	logic slot_ok;
	logic sample_low;
	logic recover_hi;
	logic start_go;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Clock and line share one path depth, so at a detected edge
	// line_q still holds the level of the clock just ended.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pci_s1 <= 1'b0;
			pci_s2 <= 1'b0;
			pci_q <= 1'b0;
			line_s1 <= 1'b1;
			line_s2 <= 1'b1;
			line_q <= 1'b1;
			brst_s1 <= 1'b1;
			brst_s2 <= 1'b1;
		end else if (ce) begin
			pci_s1 <= link.pci_clk;
			pci_s2 <= pci_s1;
			pci_q <= pci_s2;
			line_s1 <= link.line;
			line_s2 <= line_s1;
			line_q <= line_s2;
			brst_s1 <= link.bus_rst;
			brst_s2 <= brst_s1;
		end
	end

	assign tick = ce && pci_s2 && !pci_q; // RL22

	// ----------------------------------------
	// Cycle tracking
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		quiet_nxt = quiet_r;
		unique case (state_r)
			ST_IDLE: begin
				if (!line_q) begin
					state_nxt = ST_START;
					cnt_nxt = 8'h01;
				end
			end
			ST_START: begin
				if (line_q) begin
					state_nxt = ST_FRAMES; // RL12
					cnt_nxt = 8'h01;
				end
			end
			ST_FRAMES: begin
				if (cnt_r >= STOP_FROM && !line_q) begin
					state_nxt = ST_STOP; // RL20
					cnt_nxt = 8'h01;
				end else if (cnt_r != CNT_MAX) begin
					cnt_nxt = cnt_r + 8'h01;
				end
			end
			ST_STOP: begin
				if (!line_q) begin
					if (cnt_r != CNT_MAX)
						cnt_nxt = cnt_r + 8'h01;
				end else begin
					quiet_nxt = (cnt_r == STOP_QUIET_CLKS); // RL2 RL9 RL11
					state_nxt = ST_IDLE; // RL21
					cnt_nxt = 8'h00;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
			cnt_r <= 8'h00;
			quiet_r <= 1'b0; // RL10
		end else if (ce) begin
			if (brst_s2) begin
				state_r <= ST_IDLE; // RL23
				cnt_r <= 8'h00;
				quiet_r <= 1'b0;
			end else if (tick) begin
				state_r <= state_nxt;
				cnt_r <= cnt_nxt;
				quiet_r <= quiet_nxt;
			end
		end
	end

	// ----------------------------------------
	// Slot values and change detection
	// ----------------------------------------
	always_comb begin
		slot_raw = irq_lvl; // RL18
		slot_raw[0] = 1'b1;
		if (!irq2_on_slot3)
			slot_raw[SLOT_SMI_IRQ2] = !(smi_req && smi_serial_en); // RL17 RL19
	end

	// Slot 0 is the unused frame and never asks for a cycle
	assign pending = |((lvl_r ^ reported_r) & 16'hfffe); // RL24

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lvl_r <= 16'hffff;
		end else if (ce && tick) begin
			lvl_r <= slot_raw; // RL24
		end
	end

	// ----------------------------------------
	// Line drive, decided for the clock now beginning
	// ----------------------------------------
	assign frame = frame_of(cnt_nxt);
	assign phase = phase_of(cnt_nxt);
	assign slot_ok = frame >= 8'h02 && frame <= 8'(SLOT_LAST_FRAME); // RL16
	assign slot_idx = slot_ok ? 4'(frame - 8'h01) : 4'h0;
	assign sample_low = state_nxt == ST_FRAMES && phase == PH_SAMPLE && slot_ok
		&& !lvl_r[slot_idx]; // RL13 RL15 RL16
	assign recover_hi = state_nxt == ST_FRAMES && phase == PH_RECOVER && drove_r; // RL14
	// Idle only: a change that misses its slot waits for the stop
	assign start_go = state_r == ST_IDLE && state_nxt == ST_IDLE && quiet_r
		&& pending; // RL4 RL6 RL7 RL21

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reported_r <= 16'hffff;
		end else if (ce) begin
			if (brst_s2) begin
				reported_r <= 16'hffff;
			end else if (tick && state_nxt == ST_FRAMES && phase == PH_SAMPLE && slot_ok) begin
				reported_r[slot_idx] <= lvl_r[slot_idx]; // RL24
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			oe_r <= 1'b0;
			o_r <= 1'b1;
			drove_r <= 1'b0;
		end else if (ce) begin
			if (brst_s2) begin
				oe_r <= 1'b0; // RL23
				o_r <= 1'b1;
				drove_r <= 1'b0;
			end else if (tick) begin
				drove_r <= sample_low;
				if (start_go) begin
					oe_r <= 1'b1; // RL3
					o_r <= 1'b0;
				end else if (sample_low) begin
					oe_r <= 1'b1; // RL13
					o_r <= 1'b0;
				end else if (recover_hi) begin
					oe_r <= 1'b1; // RL14
					o_r <= 1'b1;
				end else begin
					oe_r <= 1'b0; // RL3 RL14
					o_r <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// Dedicated management pin
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			smi_n_r <= 1'b1;
		end else if (ce) begin
			smi_n_r <= !(smi_req && smi_pin_en); // RL19
		end
	end

	assign link.dev_oe = oe_r;
	assign link.dev_o = o_r;
	assign sys_mgmt_irq_out_n = smi_n_r;
	assign quiet_mode = quiet_r;
	assign cycle_active = state_r != ST_IDLE;

endmodule : serial_irq_slave_agent

`default_nettype wire

//--- sim/serial_irq_link_asserts.sv
`default_nettype none

module serial_irq_link_asserts
	import serial_irq_pkg::*;
#(
	parameter int NUM_FRAMES = FRAMES_MIN
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic pci_clk,
	input wire logic bus_rst,
	input wire logic host_o,
	input wire logic host_oe,
	input wire logic dev_o,
	input wire logic dev_oe,
	input wire logic line
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Link position, one link clock behind the wire
	// ----------------------------------------
	localparam int LAST = 3 * NUM_FRAMES + 1;
	localparam logic [7:0] STOP_POS = 8'(LAST + 3);
	logic [7:0] run_r;
	logic [7:0] pos_r;
	logic [7:0] since_r;
	logic [7:0] stop_r;
	logic dev_low;
	logic start_rise;
	logic stop_rise;
	logic line_d;
	assign dev_low = dev_oe && !dev_o;
	// Stop lows are 2 or 3 long, so 4 or more can only be a start
	assign start_rise = line_d && run_r >= 8'h04;
	assign stop_rise = line_d && (run_r == 8'h02 || run_r == 8'h03) && pos_r >= STOP_POS;
	// Host drive moves in the step the link clock rises, so count from a sys-clock copy to avoid a race
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			line_d <= 1'b1;
		end else begin
			line_d <= line;
		end
	end
	always_ff @(posedge pci_clk or posedge bus_rst) begin
		if (bus_rst) begin
			run_r <= 8'h00;
		end else if (line_d) begin
			run_r <= 8'h00;
		end else if (run_r != CNT_MAX) begin
			run_r <= run_r + 8'h01;
		end
	end
	always_ff @(posedge pci_clk or posedge bus_rst) begin
		if (bus_rst) begin
			pos_r <= CNT_MAX;
		end else if (start_rise) begin
			pos_r <= 8'h01;
		end else if (pos_r != CNT_MAX) begin
			pos_r <= pos_r + 8'h01;
		end
	end
	always_ff @(posedge pci_clk or posedge bus_rst) begin
		if (bus_rst) begin
			since_r <= CNT_MAX;
			stop_r <= STOP_CONT_CLKS;
		end else if (stop_rise) begin
			since_r <= 8'h01;
			stop_r <= run_r;
		end else if (since_r != CNT_MAX) begin
			since_r <= since_r + 8'h01;
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_start_width;
		@(posedge pci_clk) disable iff (bus_rst) start_rise |-> run_r <= 8'h08;
	endproperty
	a_start_width: assert property (p_start_width) else $error("start pulse too long");
	property p_host_take;
		@(posedge pci_clk) disable iff (bus_rst) dev_low && pos_r > LAST |=> host_oe && !host_o;
	endproperty
	a_host_take: assert property (p_host_take) else $error("host did not extend start");
	property p_dev_start;
		@(posedge pci_clk) disable iff (bus_rst)
		dev_low && pos_r > LAST |-> (stop_r == STOP_QUIET_CLKS && since_r >= 8'h02) ##1 !dev_oe;
	endproperty
	a_dev_start: assert property (p_dev_start) else $error("illegal device start");
	property p_sample_phase;
		@(posedge pci_clk) disable iff (bus_rst) dev_low && pos_r <= LAST |-> pos_r % 8'h03 == 8'h02;
	endproperty
	a_sample_phase: assert property (p_sample_phase) else $error("low outside sample phase");
	property p_one_low;
		@(posedge pci_clk) disable iff (bus_rst) dev_low |=> !dev_low;
	endproperty
	a_one_low: assert property (p_one_low) else $error("device low two clocks");
	property p_recover;
		@(posedge pci_clk) disable iff (bus_rst) dev_oe && dev_o |-> $past(dev_low) ##1 !dev_oe;
	endproperty
	a_recover: assert property (p_recover) else $error("bad recovery or turn-around");
	property p_stop_late;
		@(posedge pci_clk) disable iff (bus_rst)
		$rose(line) && (run_r == 8'h02 || run_r == 8'h03) |-> pos_r >= STOP_POS;
	endproperty
	a_stop_late: assert property (p_stop_late) else $error("stop before data frames end");
	property p_reset_rel;
		@(posedge sys_clk) disable iff (rst) bus_rst [*5] |-> !dev_oe;
	endproperty
	a_reset_rel: assert property (p_reset_rel) else $error("device drives in bus reset");
endmodule : serial_irq_link_asserts

`default_nettype wire

//--- sim/tb_top.sv
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Stimulus and checks
	// ----------------------------------------
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic [2:0] start_low = 3'h3;
	logic stop_quiet = 1'b0;
	logic run_continuous = 1'b0;
	logic cycle_req = 1'b0;
	logic bus_rst_req = 1'b1;
	logic [15:0] irq_lvl = 16'hffff;
	logic smi_req = 1'b0;
	logic smi_serial_en = 1'b0;
	logic smi_pin_en = 1'b0;
	logic irq2_on_slot3 = 1'b0;
	logic [15:0] slot_lvl;
	logic cycle_done;
	logic host_quiet;
	logic dev_quiet;
	logic dev_active;
	logic sys_mgmt_irq_out_n;
	logic prev_q = 1'b0;
	logic hit;
	logic [31:0] seed = 32'h921e2e21;
	int miscompares = 0;
	int n_tests = 0;
	always #2 sys_clk = ~sys_clk;
	serial_irq_if serial_irq_if_inst ();
	serial_irq_host_ctrl serial_irq_host_ctrl_inst (.sys_clk(sys_clk), .rst(rst), .ce(ce), .link(serial_irq_if_inst),
		.start_low(start_low), .stop_quiet(stop_quiet), .run_continuous(run_continuous), .cycle_req(cycle_req),
		.bus_rst_req(bus_rst_req), .slot_lvl(slot_lvl), .cycle_done(cycle_done), .quiet_mode(host_quiet));
	serial_irq_slave_agent serial_irq_slave_agent_inst (.sys_clk(sys_clk), .rst(rst), .ce(ce),
		.link(serial_irq_if_inst), .irq_lvl(irq_lvl), .smi_req(smi_req), .smi_serial_en(smi_serial_en),
		.smi_pin_en(smi_pin_en), .irq2_on_slot3(irq2_on_slot3), .sys_mgmt_irq_out_n(sys_mgmt_irq_out_n),
		.quiet_mode(dev_quiet), .cycle_active(dev_active));
	serial_irq_link_asserts link_chk (.sys_clk(sys_clk), .rst(rst), .pci_clk(serial_irq_if_inst.pci_clk),
		.bus_rst(serial_irq_if_inst.bus_rst), .host_o(serial_irq_if_inst.host_o),
		.host_oe(serial_irq_if_inst.host_oe), .dev_o(serial_irq_if_inst.dev_o),
		.dev_oe(serial_irq_if_inst.dev_oe), .line(serial_irq_if_inst.line));
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		logic [31:0] v;
		v = s;
		for (int i = 0; i < 32; i++) begin
			v = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
		end
		return v;
	endfunction : lfsr_next
	function automatic logic [15:0] exp_slots(input logic [15:0] lv, input logic sel, input logic smi, input logic en);
		logic [15:0] e;
		e = lv;
		e[0] = 1'b1;
		e[2] = sel ? lv[2] : !(smi && en);
		return e;
	endfunction : exp_slots
	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : give_verdict
	task automatic chk1(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk1
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk16
	task automatic wait_sig(input int which, input logic lvl, input int lim, input logic must);
		hit = 1'b0;
		for (int k = 0; k < lim && !hit; k++) begin
			@(negedge sys_clk);
			hit = ((which == 0) ? cycle_done : dev_active) === lvl;
		end
		if (must && !hit) begin
			miscompares++;
			give_verdict();
		end
	endtask : wait_sig
	task automatic end_cycle();
		wait_sig(0, 1'b1, 3000, 1'b1);
		// Device measures the stop some sys clocks after the host does
		repeat (6) @(negedge sys_clk);
		chk16(slot_lvl, exp_slots(irq_lvl, irq2_on_slot3, smi_req, smi_serial_en));
		chk1(dev_quiet, stop_quiet);
		chk1(host_quiet, stop_quiet);
		chk1(sys_mgmt_irq_out_n, !(smi_req && smi_pin_en));
		prev_q = stop_quiet;
	endtask : end_cycle
	task automatic run_cycle(input logic [31:0] r);
		@(negedge sys_clk);
		irq_lvl = r[15:0];
		start_low = 3'h3 + (r[18:16] % 3'h5);
		stop_quiet = r[19];
		irq2_on_slot3 = r[20];
		smi_req = r[21];
		smi_serial_en = r[22];
		smi_pin_en = r[23];
		cycle_req = 1'b1;
		wait_sig(1, 1'b1, 400, 1'b1);
		cycle_req = 1'b0;
		repeat (100) @(negedge sys_clk);
		chk1(dev_quiet, prev_q);
		end_cycle();
	endtask : run_cycle
	task automatic probe(input logic [31:0] r);
		int idx;
		idx = int'(r[31:24] % 8'h0e) + 2;
		// Slot 2 may be hidden behind the management bit, so it cannot force a start
		if (idx == 2) begin
			idx = 1;
		end
		wait_sig(1, 1'b0, 1000, 1'b1);
		irq_lvl[idx] = !irq_lvl[idx];
		wait_sig(1, 1'b1, 400, 1'b0);
		chk1(hit, prev_q);
		if (hit) begin
			end_cycle();
		end
	endtask : probe
	initial begin
		repeat (16) @(negedge sys_clk);
		rst = 1'b0;
		@(negedge sys_clk);
		chk1(dev_quiet, 1'b0);
		chk1(dev_active, 1'b0);
		chk16(slot_lvl, 16'hffff);
		chk1(sys_mgmt_irq_out_n, 1'b1);
		repeat (30) @(negedge sys_clk);
		bus_rst_req = 1'b0;
		repeat (40) @(negedge sys_clk);
		run_cycle(32'h0000_0000);
		probe(32'h0300_0000);
		run_cycle(32'h00ff_ffff);
		probe(32'h0d00_0000);
		for (int i = 0; i < 10; i++) begin
			seed = lfsr_next(seed);
			run_cycle(seed);
			seed = lfsr_next(seed);
			probe(seed);
		end
		run_cycle(32'h0000_1234);
		run_continuous = 1'b1;
		// Freeze both ends mid-cycle; the cycle must resume intact
		repeat (150) @(negedge sys_clk);
		ce = 1'b0;
		repeat (60) @(negedge sys_clk);
		chk1(dev_active, 1'b1);
		chk1(cycle_done, 1'b0);
		ce = 1'b1;
		end_cycle();
		end_cycle();
		run_continuous = 1'b0;
		wait_sig(1, 1'b0, 1000, 1'b1);
		run_cycle(32'h00f8_a5c3);
		cycle_req = 1'b1;
		wait_sig(1, 1'b1, 400, 1'b1);
		cycle_req = 1'b0;
		repeat (200) @(negedge sys_clk);
		bus_rst_req = 1'b1;
		repeat (30) @(negedge sys_clk);
		chk1(dev_active, 1'b0);
		chk1(dev_quiet, 1'b0);
		bus_rst_req = 1'b0;
		prev_q = 1'b0;
		repeat (40) @(negedge sys_clk);
		run_cycle(32'h0004_5a5a);
		give_verdict();
	end
endmodule : tb_top

`default_nettype wire
